// >>> mcs_pkg.sv
package mcs_pkg;

	// ****************************************
	// Register locations
	// ****************************************
	localparam logic [7:0] ADDR_ALU_RESULT_HOLDER = 8'h05;
	localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW_BYTE = 8'h06;
	localparam logic [7:0] ADDR_TABLE_READ_POINTER = 8'h07;
	localparam logic [7:0] ADDR_TABLE_HIGH_LATCH = 8'h08;
	localparam logic [7:0] ADDR_CORE_FLAGS = 8'h0a;
	localparam logic [7:0] ADDR_IRQ_ENABLE_REG = 8'h0b;
	localparam logic [7:0] ADDR_TIMER_COUNT_VALUE = 8'h0d;
	localparam logic [7:0] ADDR_TIMER_SETUP_REG = 8'h0e;
	localparam logic [7:0] ADDR_PORT_BASE = 8'h12;
	localparam logic [7:0] ADDR_PORT_STRIDE = 8'h02;
	localparam int NUM_PORTS = 4;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int FLAG_WORD_OUTFLOW = 0;
	localparam int FLAG_NIBBLE_OUTFLOW = 1;
	localparam int FLAG_RESULT_NULL = 2;
	localparam int FLAG_SIGNED_WRAP = 3;
	localparam int FLAG_HALT_ENTERED = 4;
	localparam int FLAG_WATCHDOG_EXPIRED = 5;
	localparam logic [7:0] FLAG_SW_MASK = 8'h0f;
	localparam int IRQ_GLOBAL_GATE = 0;
	localparam int IRQ_EXT_ENABLE = 1;
	localparam int IRQ_TIMER_ENABLE = 2;
	localparam logic [7:0] IRQ_ENABLE_MASK = 8'h07;
	localparam int TIMER_RUN_BIT = 4;
	localparam int TIMER_MODE_LSB = 6;
	localparam logic [7:0] TIMER_SETUP_MASK = 8'hd0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PORT_DATA = 8'h00;
	localparam logic [7:0] RST_PORT_DIRECTION = 8'hff;

	typedef enum logic [3:0] {
		MCS_ALU_NOP = 4'h0,
		MCS_ALU_ADD = 4'h1,
		MCS_ALU_ADC = 4'h2,
		MCS_ALU_SUB = 4'h3,
		MCS_ALU_SBC = 4'h4,
		MCS_ALU_AND = 4'h5,
		MCS_ALU_OR = 4'h6,
		MCS_ALU_XOR = 4'h7,
		MCS_ALU_RLC = 4'h8,
		MCS_ALU_RRC = 4'h9
	} mcs_alu_op_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic wr_from_acc;
		logic bit_set;
		logic bit_clr;
		logic [2:0] bit_idx;
		logic [7:0] addr;
		logic [7:0] data;
	} mcs_mem_req_t;

	typedef struct packed {
		logic valid;
		mcs_alu_op_t op;
		logic [7:0] operand;
	} mcs_alu_req_t;

	typedef struct packed {
		logic sleep_exec;
		logic watchdog_kick_instruction;
		logic watchdog_timeout;
		logic irq_entry;
		logic irq_return_instruction;
	} mcs_core_evt_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] program_counter_low_byte;
		logic [7:0] table_read_pointer;
		logic [7:0] table_high_latch;
		logic [7:0] flags;
		logic [7:0] irq_en;
		logic [7:0] tcount;
		logic [7:0] tsetup;
		logic [NUM_PORTS-1:0][7:0] pdata;
		logic [NUM_PORTS-1:0][7:0] pdir;
		logic [NUM_PORTS-1:0][7:0] poe;
		logic [NUM_PORTS-1:0][7:0] sync1;
		logic [NUM_PORTS-1:0][7:0] sync2;
		logic [NUM_PORTS-1:0][7:0] sync3;
		logic [NUM_PORTS-1:0][7:0] pin_lvl;
		logic [7:0] rd_data;
		logic rd_valid;
		logic jump;
		logic dummy;
		logic [7:0] jump_tgt;
		logic fetch;
		logic [7:0] fetch_addr;
		logic low_valid;
		logic [7:0] low_byte;
		logic t_ovf;
	} mcs_state_t;

endpackage : mcs_pkg

// >>> mcs_core_regs.sv
`timescale 1ns/1ns
`default_nettype none
module mcs_core_regs import mcs_pkg::*; #(
	parameter int PROG_W = 16
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire mcs_mem_req_t mem_req,
	input wire mcs_alu_req_t alu_req,
	input wire mcs_core_evt_t core_evt,
	input wire logic tbl_read,
	input wire logic tbl_word_valid,
	input wire logic [PROG_W-1:0] tbl_word,
	input wire logic timer_tick,
	input wire logic [NUM_PORTS*8-1:0] pin_in,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic [7:0] alu_result_holder,
	output logic pcl_jump,
	output logic [7:0] pcl_jump_target,
	output logic dummy_cycle,
	output logic tbl_fetch,
	output logic [7:0] tbl_fetch_addr,
	output logic tbl_low_valid,
	output logic [7:0] tbl_low_byte,
	output logic [7:0] core_flags,
	output logic [7:0] irq_enable_reg,
	output logic [7:0] timer_count_value,
	output logic [7:0] timer_setup_reg,
	output logic timer_overflow,
	output logic [NUM_PORTS*8-1:0] pin_out,
	output logic [NUM_PORTS*8-1:0] pin_oe
);

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic logic [7:0] port_view(input logic [7:0] data, input logic [7:0] dir,
		input logic [7:0] lvl);
		// Inputs show the pin, outputs show the latch
		port_view = (dir & lvl) | (~dir & data);
	endfunction : port_view

	function automatic logic [7:0] stored_value(input mcs_state_t s, input logic [7:0] addr);
		stored_value = 8'h00;
		case (addr)
			ADDR_ALU_RESULT_HOLDER: stored_value = s.acc;
			ADDR_PROGRAM_COUNTER_LOW_BYTE: stored_value = s.program_counter_low_byte;
			ADDR_TABLE_READ_POINTER: stored_value = s.table_read_pointer;
			ADDR_TABLE_HIGH_LATCH: stored_value = s.table_high_latch;
			ADDR_CORE_FLAGS: stored_value = s.flags;
			ADDR_IRQ_ENABLE_REG: stored_value = s.irq_en;
			ADDR_TIMER_COUNT_VALUE: stored_value = s.tcount;
			ADDR_TIMER_SETUP_REG: stored_value = s.tsetup;
			default: begin
				for (int i = 0; i < NUM_PORTS; i++) begin
					if (addr == ADDR_PORT_BASE + 8'(i) * ADDR_PORT_STRIDE) begin
						stored_value = s.pdata[i];
					end
					if (addr == ADDR_PORT_BASE + 8'(i) * ADDR_PORT_STRIDE + 8'h01) begin
						stored_value = s.pdir[i];
					end
				end
			end
		endcase
	endfunction : stored_value

	function automatic logic [7:0] read_value(input mcs_state_t s, input logic [7:0] addr);
		read_value = stored_value(s, addr);
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (addr == ADDR_PORT_BASE + 8'(i) * ADDR_PORT_STRIDE) begin
				read_value = port_view(s.pdata[i], s.pdir[i], s.pin_lvl[i]);
			end
		end
	endfunction : read_value

	// Read-modify-write for single-bit instructions acts on the latch, not the pin
	function automatic logic [7:0] merge_bits(input logic [7:0] old, input mcs_mem_req_t r,
		input logic [7:0] acc);
		logic [7:0] m;
		m = 8'h01 << r.bit_idx;
		if (r.bit_set) begin
			merge_bits = old | m;
		end else if (r.bit_clr) begin
			merge_bits = old & ~m;
		end else if (r.wr_from_acc) begin
			merge_bits = acc;
		end else begin
			merge_bits = r.data;
		end
	endfunction : merge_bits

	// Returns {new flags, result}; halt and watchdog bits pass through
	function automatic logic [15:0] alu_exec(input mcs_alu_op_t op, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] f);
		logic [8:0] sum;
		logic [4:0] low;
		logic [7:0] low7;
		logic [7:0] bb;
		logic [7:0] res;
		logic [7:0] nf;
		logic cin;
		sum = 9'h000;
		low = 5'h00;
		low7 = 8'h00;
		bb = b;
		res = a;
		nf = f;
		cin = 1'b0;
		case (op)
			MCS_ALU_ADD, MCS_ALU_ADC, MCS_ALU_SUB, MCS_ALU_SBC: begin
				// Subtraction is addition of the complement, so carry means no borrow
				bb = (op == MCS_ALU_SUB || op == MCS_ALU_SBC) ? ~b : b;
				cin = (op == MCS_ALU_SUB) ? 1'b1 :
					(op == MCS_ALU_ADD) ? 1'b0 : f[FLAG_WORD_OUTFLOW];
				sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
				low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
				low7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
				res = sum[7:0];
				nf[FLAG_WORD_OUTFLOW] = sum[8];
				nf[FLAG_NIBBLE_OUTFLOW] = low[4];
				nf[FLAG_SIGNED_WRAP] = low7[7] ^ sum[8];
				nf[FLAG_RESULT_NULL] = (res == 8'h00);
			end
			MCS_ALU_AND, MCS_ALU_OR, MCS_ALU_XOR: begin
				res = (op == MCS_ALU_AND) ? (a & b) : (op == MCS_ALU_OR) ? (a | b) : (a ^ b);
				nf[FLAG_RESULT_NULL] = (res == 8'h00);
			end
			MCS_ALU_RLC: begin
				res = {a[6:0], f[FLAG_WORD_OUTFLOW]};
				nf[FLAG_WORD_OUTFLOW] = a[7];
			end
			MCS_ALU_RRC: begin
				res = {f[FLAG_WORD_OUTFLOW], a[7:1]};
				nf[FLAG_WORD_OUTFLOW] = a[0];
			end
			default: begin
				res = a;
			end
		endcase
		alu_exec = {nf, res};
	endfunction : alu_exec

	// ****************************************
	// State
	// ****************************************
	mcs_state_t state_reg;
	mcs_state_t state_next;

	always_comb begin
		logic [7:0] wval;
		logic [15:0] alu_out;
		logic [8:0] tnext;
		wval = merge_bits(stored_value(state_reg, mem_req.addr), mem_req, state_reg.acc);
		alu_out = alu_exec(alu_req.op, state_reg.acc, alu_req.operand, state_reg.flags);
		tnext = {1'b0, state_reg.tcount} + 9'h001;
		state_next = state_reg;
		state_next.jump = 1'b0;
		state_next.fetch = 1'b0;
		state_next.low_valid = 1'b0;
		state_next.rd_valid = 1'b0;
		state_next.t_ovf = 1'b0;
		state_next.dummy = state_reg.jump;

		// Pins: three stages; a rise counts once stages two and three agree, any disagreement between them clears the level
		state_next.sync1 = pin_in;
		state_next.sync2 = state_reg.sync1;
		state_next.sync3 = state_reg.sync2;
		state_next.pin_lvl = (state_reg.sync2 & state_reg.sync3) |
			(state_reg.pin_lvl & ~(state_reg.sync2 ^ state_reg.sync3));

		if (mem_req.rd) begin
			state_next.rd_valid = 1'b1;
			state_next.rd_data = read_value(state_reg, mem_req.addr);
		end

		// Timer runs before writes so a preload in the same cycle wins
		if (state_reg.tsetup[TIMER_RUN_BIT] && timer_tick) begin
			state_next.tcount = tnext[7:0];
			state_next.t_ovf = tnext[8];
		end

		if (mem_req.wr || mem_req.bit_set || mem_req.bit_clr) begin
			case (mem_req.addr)
				ADDR_ALU_RESULT_HOLDER: state_next.acc = wval;
				ADDR_PROGRAM_COUNTER_LOW_BYTE: begin
					// Only the low byte moves, so the target stays in the current page
					state_next.program_counter_low_byte = wval;
					state_next.jump = 1'b1;
					state_next.jump_tgt = wval;
				end
				ADDR_TABLE_READ_POINTER: state_next.table_read_pointer = wval;
				ADDR_CORE_FLAGS: begin
					state_next.flags = (wval & FLAG_SW_MASK) |
						(state_reg.flags & ~FLAG_SW_MASK);
				end
				ADDR_IRQ_ENABLE_REG: state_next.irq_en = wval & IRQ_ENABLE_MASK;
				ADDR_TIMER_COUNT_VALUE: state_next.tcount = wval;
				ADDR_TIMER_SETUP_REG: state_next.tsetup = wval & TIMER_SETUP_MASK;
				default: begin
					for (int i = 0; i < NUM_PORTS; i++) begin
						if (mem_req.addr == ADDR_PORT_BASE + 8'(i) * ADDR_PORT_STRIDE) begin
							state_next.pdata[i] = wval;
						end
						if (mem_req.addr == ADDR_PORT_BASE + 8'(i) * ADDR_PORT_STRIDE + 8'h01) begin
							state_next.pdir[i] = wval;
						end
					end
				end
			endcase
		end

		// ALU result goes to the accumulator; it overrides a plain write there
		if (alu_req.valid && alu_req.op != MCS_ALU_NOP) begin
			state_next.acc = alu_out[7:0];
			state_next.flags[FLAG_SIGNED_WRAP:0] = alu_out[8+FLAG_SIGNED_WRAP:8];
		end

		// Clears first, then sets, so a set in the same cycle is never lost
		if (core_evt.watchdog_kick_instruction) begin
			state_next.flags[FLAG_HALT_ENTERED] = 1'b0;
			state_next.flags[FLAG_WATCHDOG_EXPIRED] = 1'b0;
		end
		if (core_evt.sleep_exec) begin
			state_next.flags[FLAG_WATCHDOG_EXPIRED] = 1'b0;
			state_next.flags[FLAG_HALT_ENTERED] = 1'b1;
		end
		if (core_evt.watchdog_timeout) begin
			state_next.flags[FLAG_WATCHDOG_EXPIRED] = 1'b1;
		end

		// Entry only drops the gate; flags are left for software to save
		if (core_evt.irq_entry) begin
			state_next.irq_en[IRQ_GLOBAL_GATE] = 1'b0;
		end
		if (core_evt.irq_return_instruction) begin
			state_next.irq_en[IRQ_GLOBAL_GATE] = 1'b1;
		end

		if (tbl_read) begin
			state_next.fetch = 1'b1;
			state_next.fetch_addr = state_reg.table_read_pointer;
		end
		if (tbl_word_valid) begin
			state_next.table_high_latch = 8'(tbl_word >> 8);
			state_next.low_byte = tbl_word[7:0];
			state_next.low_valid = 1'b1;
		end

		state_next.poe = ~state_next.pdir;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_reg <= '0;
			state_reg.acc <= RST_ZERO;
			state_reg.flags <= RST_ZERO;
			state_reg.irq_en <= RST_ZERO;
			state_reg.tsetup <= RST_ZERO;
			state_reg.pdata <= {NUM_PORTS{RST_PORT_DATA}};
			state_reg.pdir <= {NUM_PORTS{RST_PORT_DIRECTION}};
			state_reg.poe <= {NUM_PORTS{~RST_PORT_DIRECTION}};
		end else begin
			state_reg <= state_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rd_data = state_reg.rd_data;
	assign rd_valid = state_reg.rd_valid;
	assign alu_result_holder = state_reg.acc;
	assign pcl_jump = state_reg.jump;
	assign pcl_jump_target = state_reg.jump_tgt;
	assign dummy_cycle = state_reg.dummy;
	assign tbl_fetch = state_reg.fetch;
	assign tbl_fetch_addr = state_reg.fetch_addr;
	assign tbl_low_valid = state_reg.low_valid;
	assign tbl_low_byte = state_reg.low_byte;
	assign core_flags = state_reg.flags;
	assign irq_enable_reg = state_reg.irq_en;
	assign timer_count_value = state_reg.tcount;
	assign timer_setup_reg = state_reg.tsetup;
	assign timer_overflow = state_reg.t_ovf;
	assign pin_out = state_reg.pdata;
	assign pin_oe = state_reg.poe;

endmodule : mcs_core_regs
`default_nettype wire

// >>> mcs_core_regs_sva.sv
`timescale 1ns/1ns
`default_nettype none
module mcs_core_regs_sva import mcs_pkg::*; (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire mcs_mem_req_t mem_req,
	input wire mcs_alu_req_t alu_req,
	input wire mcs_core_evt_t core_evt,
	input wire logic timer_tick,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	input wire logic [7:0] alu_result_holder,
	input wire logic pcl_jump,
	input wire logic [7:0] pcl_jump_target,
	input wire logic dummy_cycle,
	input wire logic tbl_fetch,
	input wire logic [7:0] core_flags,
	input wire logic [7:0] irq_enable_reg,
	input wire logic [7:0] timer_count_value,
	input wire logic [7:0] timer_setup_reg,
	input wire logic [NUM_PORTS*8-1:0] pin_oe
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic wr_plain;
	assign wr_plain = mem_req.wr && !mem_req.wr_from_acc && !mem_req.bit_set && !mem_req.bit_clr;
	chk_unused_zero: assert property (
		mem_req.rd && mem_req.addr == 8'h09 |=> rd_valid && rd_data == 8'h00)
		else $error("unused location read nonzero");
	chk_pcl_jump: assert property (
		wr_plain && mem_req.addr == ADDR_PROGRAM_COUNTER_LOW_BYTE
		|=> pcl_jump && pcl_jump_target == $past(mem_req.data)) else $error("no jump");
	chk_dummy_follow: assert property (
		pcl_jump |=> dummy_cycle ##1 !dummy_cycle) else $error("dummy cycle missing");
	chk_halt_stable: assert property (
		!core_evt.sleep_exec && !core_evt.watchdog_kick_instruction
		|=> $stable(core_flags[FLAG_HALT_ENTERED])) else $error("halt flag moved");
	chk_sleep_flags: assert property (
		core_evt.sleep_exec && !core_evt.watchdog_kick_instruction && !core_evt.watchdog_timeout
		|=> core_flags[5:4] == 2'b01) else $error("sleep flags wrong");
	chk_gate_entry: assert property (
		core_evt.irq_entry && !core_evt.irq_return_instruction && mem_req.addr != ADDR_IRQ_ENABLE_REG
		|=> !irq_enable_reg[IRQ_GLOBAL_GATE]) else $error("gate kept on entry");
	chk_null_flag: assert property (
		alu_req.valid && !(alu_req.op inside {MCS_ALU_NOP, MCS_ALU_RLC, MCS_ALU_RRC})
		|=> core_flags[FLAG_RESULT_NULL] == (alu_result_holder == 8'h00))
		else $error("null flag wrong");
	chk_dir_oe: assert property (
		wr_plain && mem_req.addr == 8'h13 |=> pin_oe[7:0] == ~$past(mem_req.data))
		else $error("output enable wrong");
	chk_timer_step: assert property (
		timer_setup_reg[TIMER_RUN_BIT] && timer_tick && mem_req.addr != ADDR_TIMER_COUNT_VALUE
		|=> timer_count_value == $past(timer_count_value) + 8'h01) else $error("timer step");
	cover property (pcl_jump);
	cover property (tbl_fetch);
	cover property (core_evt.irq_entry);
endmodule : mcs_core_regs_sva
bind mcs_core_regs mcs_core_regs_sva mcs_core_regs_sva_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.mem_req(mem_req), .alu_req(alu_req), .core_evt(core_evt), .timer_tick(timer_tick),
	.rd_data(rd_data), .rd_valid(rd_valid), .alu_result_holder(alu_result_holder),
	.pcl_jump(pcl_jump), .pcl_jump_target(pcl_jump_target), .dummy_cycle(dummy_cycle),
	.tbl_fetch(tbl_fetch), .core_flags(core_flags), .irq_enable_reg(irq_enable_reg),
	.timer_count_value(timer_count_value), .timer_setup_reg(timer_setup_reg), .pin_oe(pin_oe));
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb import mcs_pkg::*;;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	mcs_mem_req_t mem_req = '0;
	mcs_alu_req_t alu_req = '0;
	mcs_core_evt_t core_evt = '0;
	logic tbl_read = 1'b0;
	logic tbl_word_valid = 1'b0;
	logic [15:0] tbl_word = 16'h0000;
	logic timer_tick = 1'b0;
	logic [31:0] pin_in = 32'h00000000;
	logic [7:0] rd_data, alu_result_holder, pcl_jump_target, tbl_fetch_addr, tbl_low_byte;
	logic [7:0] core_flags, irq_enable_reg, timer_count_value, timer_setup_reg;
	logic rd_valid, pcl_jump, dummy_cycle, tbl_fetch, tbl_low_valid, timer_overflow;
	logic [31:0] pin_out, pin_oe;
	logic [7:0] lf = 8'h36;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	int acc = 0;
	int flg = 0;
	mcs_core_regs mcs_core_regs_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .mem_req(mem_req),
		.alu_req(alu_req), .core_evt(core_evt), .tbl_read(tbl_read), .tbl_word_valid(tbl_word_valid),
		.tbl_word(tbl_word), .timer_tick(timer_tick), .pin_in(pin_in), .rd_data(rd_data),
		.rd_valid(rd_valid), .alu_result_holder(alu_result_holder), .pcl_jump(pcl_jump),
		.pcl_jump_target(pcl_jump_target), .dummy_cycle(dummy_cycle), .tbl_fetch(tbl_fetch),
		.tbl_fetch_addr(tbl_fetch_addr), .tbl_low_valid(tbl_low_valid), .tbl_low_byte(tbl_low_byte),
		.core_flags(core_flags), .irq_enable_reg(irq_enable_reg), .timer_count_value(timer_count_value),
		.timer_setup_reg(timer_setup_reg), .timer_overflow(timer_overflow), .pin_out(pin_out),
		.pin_oe(pin_oe));
	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : nxt
	// One request for one cycle, then idle; results are sampled 1 ns after the answer edge
	task automatic op(input mcs_mem_req_t m, input mcs_alu_req_t a, input mcs_core_evt_t e,
		input logic [2:0] s);
		@(posedge ref_clk);
		mem_req <= m;
		alu_req <= a;
		core_evt <= e;
		{timer_tick, tbl_read, tbl_word_valid} <= s;
		@(posedge ref_clk);
		mem_req <= '0;
		alu_req <= '0;
		core_evt <= '0;
		{timer_tick, tbl_read, tbl_word_valid} <= 3'h0;
		#1;
	endtask : op
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		op({5'h08, 3'h0, ad, d}, '0, '0, 3'h0);
	endtask : wr
	task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
		op({5'h10, 3'h0, ad, 8'h00}, '0, '0, 3'h0);
		chk(8'(rd_valid), 8'h01);
		chk(rd_data, exp);
	endtask : rdc
	// Flag model keeps halt and watchdog bits in 5:4 so one compare covers the byte
	function automatic int alu_m(input int o, input int a, input int b);
		int ci;
		int bb;
		int s;
		ci = (o == 2 || o == 4) ? flg & 1 : (o == 3 ? 1 : 0);
		bb = (o == 3 || o == 4) ? ~b & 8'hff : b;
		if (o <= 4) begin
			s = a + bb + ci;
			flg = (flg & 8'h30) | (((((a & 8'h7f) + (bb & 8'h7f) + ci) >> 7) ^ (s >> 8)) << 3);
			flg = flg | ((s & 8'hff) == 0 ? 4 : 0) | ((((a & 8'h0f) + (bb & 8'h0f) + ci) >> 4) << 1);
			flg = flg | (s >> 8);
			return s & 8'hff;
		end
		if (o == 8) begin
			s = ((a << 1) | (flg & 1)) & 8'hff;
			flg = (flg & 8'hfe) | (a >> 7);
			return s;
		end
		if (o == 9) begin
			s = ((flg & 1) << 7) | (a >> 1);
			flg = (flg & 8'hfe) | (a & 1);
			return s;
		end
		s = o == 5 ? a & b : (o == 6 ? a | b : a ^ b);
		flg = (flg & 8'hfb) | (s == 0 ? 4 : 0);
		return s;
	endfunction : alu_m
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		for (int k = 0; k < 32; k++) begin
			rdc(8'(k), (k >= 18 && k <= 25 && k % 2 == 1) ? 8'hff : 8'h00);
		end
		wr(ADDR_TABLE_HIGH_LATCH, 8'h5a);
		rdc(ADDR_TABLE_HIGH_LATCH, 8'h00);
		$display("reset map test done");
		for (int k = 0; k < 36; k++) begin
			lf = nxt(lf);
			wr(ADDR_ALU_RESULT_HOLDER, lf);
			acc = lf;
			lf = nxt(lf);
			acc = alu_m(k % 9 + 1, acc, lf);
			op('0, {1'b1, 4'(k % 9 + 1), lf}, '0, 3'h0);
			chk(alu_result_holder, 8'(acc));
			chk(core_flags, 8'(flg));
		end
		$display("alu test done");
		wr(ADDR_CORE_FLAGS, 8'hff);
		chk(core_flags, 8'h0f);
		op('0, '0, 5'h10, 3'h0);
		chk(core_flags, 8'h1f);
		op('0, '0, 5'h04, 3'h0);
		chk(core_flags, 8'h3f);
		wr(ADDR_CORE_FLAGS, 8'h00);
		rdc(ADDR_CORE_FLAGS, 8'h30);
		op('0, '0, 5'h08, 3'h0);
		chk(core_flags, 8'h00);
		$display("flag test done");
		lf = nxt(lf);
		wr(ADDR_PROGRAM_COUNTER_LOW_BYTE, lf);
		chk(8'(pcl_jump), 8'h01);
		chk(pcl_jump_target, lf);
		@(posedge ref_clk);
		#1;
		chk(8'(dummy_cycle), 8'h01);
		op({5'h0c, 3'h0, ADDR_PROGRAM_COUNTER_LOW_BYTE, 8'h00}, '0, '0, 3'h0);
		chk(pcl_jump_target, 8'(acc));
		$display("jump test done");
		wr(ADDR_TABLE_READ_POINTER, lf);
		op('0, '0, '0, 3'h2);
		chk(8'(tbl_fetch), 8'h01);
		chk(tbl_fetch_addr, lf);
		@(posedge ref_clk) tbl_word <= {lf, 8'ha5};
		op('0, '0, '0, 3'h1);
		chk(tbl_low_byte, 8'ha5);
		chk(8'(tbl_low_valid), 8'h01);
		rdc(ADDR_TABLE_HIGH_LATCH, lf);
		$display("table test done");
		wr(ADDR_IRQ_ENABLE_REG, 8'hff);
		chk(irq_enable_reg, 8'h07);
		op({5'h01, 3'h1, ADDR_IRQ_ENABLE_REG, 8'h00}, '0, '0, 3'h0);
		chk(irq_enable_reg, 8'h05);
		op('0, '0, 5'h02, 3'h0);
		chk(irq_enable_reg, 8'h04);
		chk(core_flags, 8'h00);
		op('0, '0, 5'h01, 3'h0);
		chk(irq_enable_reg, 8'h05);
		$display("irq test done");
		wr(ADDR_TIMER_SETUP_REG, 8'hff);
		chk(timer_setup_reg, 8'hd0);
		wr(ADDR_TIMER_COUNT_VALUE, 8'hfe);
		op('0, '0, '0, 3'h4);
		chk(timer_count_value, 8'hff);
		chk(8'(timer_overflow), 8'h00);
		op('0, '0, '0, 3'h4);
		chk(timer_count_value, 8'h00);
		chk(8'(timer_overflow), 8'h01);
		wr(ADDR_TIMER_SETUP_REG, 8'h00);
		op('0, '0, '0, 3'h4);
		chk(timer_count_value, 8'h00);
		$display("timer test done");
		for (int i = 0; i < 4; i++) begin
			lf = nxt(lf);
			@(posedge ref_clk) pin_in[8*i +: 8] <= lf;
			wr(ADDR_PORT_BASE + 8'(2 * i) + 8'h01, 8'h0f);
			wr(ADDR_PORT_BASE + 8'(2 * i), 8'ha5);
			chk(pin_oe[8*i +: 8], 8'hf0);
			chk(pin_out[8*i +: 8], 8'ha5);
			repeat (4) @(posedge ref_clk);
			rdc(ADDR_PORT_BASE + 8'(2 * i), (lf & 8'h0f) | 8'ha0);
			op({5'h02, 3'h7, ADDR_PORT_BASE + 8'(2 * i) + 8'h01, 8'h00}, '0, '0, 3'h0);
			chk(pin_oe[8*i +: 8], 8'h70);
			op({5'h01, 3'h0, ADDR_PORT_BASE + 8'(2 * i), 8'h00}, '0, '0, 3'h0);
			chk(pin_out[8*i +: 8], 8'ha4);
		end
		$display("port test done");
		print_verdict();
	end
endmodule : tb
`default_nettype wire
